// ### vic_core_model.sv
// Core model: registers the two active-low request lines each clock
module vic_core_model (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Request lines from the slice
    input  wire logic fast_request_out_n,
    input  wire logic normal_request_out_n,
    // What the core has taken in
    output logic      fast_seen,
    output logic      norm_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // Core samples synchronously, so it sees each line one clock late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_seen <= 1'b0;
            norm_seen <= 1'b0;
        end else begin
            fast_seen <= !fast_request_out_n;
            norm_seen <= !normal_request_out_n;
        end
    end
endmodule

// ### vic_pkg.sv
// Package: register map, field layout and state types of the vector slice
package vic_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] VIC_OFF_VEC_LO    = 12'h080;
    localparam logic [11:0] VIC_OFF_VEC_HI    = 12'h0fc;
    localparam logic [11:0] VIC_OFF_NORM_VEC  = 12'h100;
    localparam logic [11:0] VIC_OFF_FAST_VEC  = 12'h104;
    localparam logic [11:0] VIC_OFF_CUR_SRC   = 12'h108;
    localparam logic [11:0] VIC_OFF_PENDING   = 12'h10c;
    localparam logic [11:0] VIC_OFF_ENABLED   = 12'h110;
    localparam logic [11:0] VIC_OFF_CORE_REQ  = 12'h114;
    localparam logic [11:0] VIC_OFF_EN_CMD    = 12'h120;
    localparam logic [11:0] VIC_OFF_DIS_CMD   = 12'h124;
    localparam logic [11:0] VIC_OFF_CLR_CMD   = 12'h128;
    localparam logic [11:0] VIC_OFF_SET_CMD   = 12'h12c;
    localparam logic [11:0] VIC_OFF_EOS_CMD   = 12'h130;
    localparam logic [11:0] VIC_OFF_SPU_VEC   = 12'h134;
    localparam logic [11:0] VIC_OFF_EVT_STAT  = 12'h150;
    localparam logic [11:0] VIC_OFF_EVT_MASK  = 12'h154;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int VIC_FAST_BIT      = 0;
    localparam int VIC_SYS_BIT       = 1;
    localparam int VIC_LINE_FAST_BIT = 0;
    localparam int VIC_LINE_NORM_BIT = 1;
    localparam int VIC_EVT_SPUR_NORM = 0;
    localparam int VIC_EVT_SPUR_FAST = 1;
    localparam int VIC_EVT_EOS_IDLE  = 2;
    localparam int VIC_EVT_W         = 3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] VIC_RST_WORD = 32'h0000_0000;
    localparam logic [4:0]  VIC_RST_CUR  = 5'h00;

    // APB access phase, one wait state so read data leaves a flop
    typedef enum logic [1:0] {
        VIC_PH_IDLE = 2'b01,
        VIC_PH_DONE = 2'b10
    } vic_phase_t;

    typedef struct packed {
        logic [31:0]          pend;
        logic [31:0]          enab;
        logic [31:0]          spu;
        logic [31:0]          rdata;
        logic                 slverr;
        vic_phase_t           ph;
        logic [4:0]           cur;
        logic                 busy;
        logic                 fast_n;
        logic                 norm_n;
        logic [VIC_EVT_W-1:0] evt_st;
        logic [VIC_EVT_W-1:0] evt_msk;
    } vic_state_t;

endpackage

// ### vic_status_cmd.sv
// Module: status and command register slice of a vectored controller
//
// Operation
// - Current-source register returns serviced number, resets zero
// - Bit 0 fast, bit 1 system, others peripheral
// - Pending register shows pending sources as ones
// - Enabled register shows enabled sources, resets zero
// - Core status bit 0 mirrors fast request line
// - Core status bit 1 mirrors normal request line
// - Enable command sets written-one sources enabled
// - Disable command clears written-one sources enabled
// - Clear command drops pending on written-one sources
// - Set command forces pending on written-one sources
// - Any end-of-service write ends current service
// - Spurious vector register read/write, resets zero
// - Spurious normal read returns spurious vector
// - Spurious fast read returns spurious vector
// - Normal readout gives the winning pending source's vector
// - Fast readout gives source zero's vector
//
// The placing of the registers and the APB register port were decided locally.
module vic_status_cmd
    import vic_pkg::*;
#(
    parameter int NSRC = 32
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Interrupt sources, same clock domain, level held while requesting
    input  wire logic [31:0] src_req,
    // Source vector store read path
    output logic [4:0]       vec_sel,
    input  wire logic [31:0] vec_data,
    // Requests to the processor core, active low
    output logic             fast_request_out_n,
    output logic             normal_request_out_n,
    // Service event interrupt
    output logic             evt_irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Lowest-numbered normal source wins; fixed order stands in for the
    // priority arbiter that lives elsewhere in the controller.
    function automatic logic [4:0] first_src(input logic [31:0] v);
        logic [4:0] idx;
        idx = VIC_RST_CUR;
        for (int i = 31; i >= VIC_SYS_BIT; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic is_vec_reg(input logic [11:0] a);
        return (a >= VIC_OFF_VEC_LO) && (a <= VIC_OFF_VEC_HI);
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    vic_state_t s_r;
    vic_state_t s_nxt;

    logic [31:0] norm_live;
    logic        norm_any;
    logic [4:0]  norm_win;
    logic        fast_live;
    logic        acc;
    logic        fin;
    logic        wr_fin;
    logic        rd_fin;
    logic [11:0] a;
    logic        mapped;
    logic [31:0] wmask;

    always_comb begin
        norm_live = s_r.pend & s_r.enab;
        norm_live[VIC_FAST_BIT] = 1'b0;
        norm_any  = |norm_live;
        norm_win  = first_src(norm_live);
        fast_live = s_r.pend[VIC_FAST_BIT] & s_r.enab[VIC_FAST_BIT];
        acc       = psel & penable;
        fin       = acc & (s_r.ph == VIC_PH_DONE);
        wr_fin    = fin & pwrite;
        rd_fin    = fin & ~pwrite;
        a         = {paddr[11:2], 2'b00};
        mapped    = is_vec_reg(a)
                  || (a == VIC_OFF_NORM_VEC) || (a == VIC_OFF_FAST_VEC)
                  || (a == VIC_OFF_CUR_SRC)  || (a == VIC_OFF_PENDING)
                  || (a == VIC_OFF_ENABLED)  || (a == VIC_OFF_CORE_REQ)
                  || (a == VIC_OFF_EN_CMD)   || (a == VIC_OFF_DIS_CMD)
                  || (a == VIC_OFF_CLR_CMD)  || (a == VIC_OFF_SET_CMD)
                  || (a == VIC_OFF_EOS_CMD)  || (a == VIC_OFF_SPU_VEC)
                  || (a == VIC_OFF_EVT_STAT) || (a == VIC_OFF_EVT_MASK);
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{pstrb[b]}};
        end
    end

    // Vector store index follows the address being read
    always_comb begin
        if (a == VIC_OFF_FAST_VEC) begin
            vec_sel = 5'(VIC_FAST_BIT);
        end else if (a == VIC_OFF_NORM_VEC) begin
            vec_sel = norm_win;
        end else begin
            vec_sel = a[6:2];
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0] en_w;
        logic [31:0] dis_w;
        logic [31:0] clr_w;
        logic [31:0] set_w;
        logic [31:0] svc_clr;
        logic [VIC_EVT_W-1:0] evt;
        en_w    = '0;
        dis_w   = '0;
        clr_w   = '0;
        set_w   = '0;
        svc_clr = '0;
        evt     = '0;
        s_nxt   = s_r;

        // Bus phase: first access cycle loads read data, second ends it
        if (acc && s_r.ph == VIC_PH_IDLE) begin
            s_nxt.ph     = VIC_PH_DONE;
            s_nxt.slverr = ~mapped;
            s_nxt.rdata  = VIC_RST_WORD;
            if (!pwrite) begin
                if (is_vec_reg(a)) begin
                    s_nxt.rdata = vec_data;
                end else if (a == VIC_OFF_NORM_VEC) begin
                    if (norm_any && !s_r.busy) begin
                        s_nxt.rdata = vec_data;
                    end else begin
                        s_nxt.rdata = s_r.spu;
                    end
                end else if (a == VIC_OFF_FAST_VEC) begin
                    if (fast_live) begin
                        s_nxt.rdata = vec_data;
                    end else begin
                        s_nxt.rdata = s_r.spu;
                    end
                end else if (a == VIC_OFF_CUR_SRC) begin
                    s_nxt.rdata = {27'h0, s_r.cur};
                end else if (a == VIC_OFF_PENDING) begin
                    s_nxt.rdata = s_r.pend;
                end else if (a == VIC_OFF_ENABLED) begin
                    s_nxt.rdata = s_r.enab;
                end else if (a == VIC_OFF_CORE_REQ) begin
                    s_nxt.rdata = {30'h0,
                                   ~s_r.norm_n,
                                   ~s_r.fast_n};
                end else if (a == VIC_OFF_SPU_VEC) begin
                    s_nxt.rdata = s_r.spu;
                end else if (a == VIC_OFF_EVT_STAT) begin
                    s_nxt.rdata = {29'h0, s_r.evt_st};
                end else if (a == VIC_OFF_EVT_MASK) begin
                    s_nxt.rdata = {29'h0, s_r.evt_msk};
                end
            end
        end else if (fin || !acc) begin
            s_nxt.ph = VIC_PH_IDLE;
        end

        // Writes and read side effects happen only at the ready edge
        if (wr_fin) begin
            if (a == VIC_OFF_EN_CMD) begin
                en_w = pwdata;
            end else if (a == VIC_OFF_DIS_CMD) begin
                dis_w = pwdata;
            end else if (a == VIC_OFF_CLR_CMD) begin
                clr_w = pwdata;
            end else if (a == VIC_OFF_SET_CMD) begin
                set_w = pwdata;
            end else if (a == VIC_OFF_EOS_CMD) begin
                // Data ignored: the write itself marks completion
                if (!s_r.busy) begin
                    evt[VIC_EVT_EOS_IDLE] = 1'b1;
                end
                s_nxt.busy = 1'b0;
            end else if (a == VIC_OFF_SPU_VEC) begin
                s_nxt.spu = (s_r.spu & ~wmask)
                          | (pwdata & wmask);
            end else if (a == VIC_OFF_EVT_MASK) begin
                s_nxt.evt_msk = pwdata[VIC_EVT_W-1:0];
            end
        end

        if (rd_fin && a == VIC_OFF_NORM_VEC) begin
            if (norm_any && !s_r.busy) begin
                // Acknowledge: source enters service, its request is taken
                s_nxt.cur  = norm_win;
                s_nxt.busy = 1'b1;
                svc_clr[norm_win] = 1'b1;
            end else begin
                evt[VIC_EVT_SPUR_NORM] = 1'b1;
            end
        end
        if (rd_fin && a == VIC_OFF_FAST_VEC) begin
            if (fast_live) begin
                svc_clr[VIC_FAST_BIT] = 1'b1;
            end else begin
                evt[VIC_EVT_SPUR_FAST] = 1'b1;
            end
        end

        // Disable wins when both commands hit one source together
        s_nxt.enab = (s_r.enab | en_w) & ~dis_w;
        // A request or set arriving with a clear still lands
        s_nxt.pend = (s_r.pend & ~clr_w & ~svc_clr)
                   | set_w | src_req;

        s_nxt.fast_n = ~(s_nxt.pend[VIC_FAST_BIT]
                       & s_nxt.enab[VIC_FAST_BIT]);
        s_nxt.norm_n = ~((|(s_nxt.pend[31:1] & s_nxt.enab[31:1]))
                       & ~s_nxt.busy);

        // Event status: set beats write-one-to-clear
        if (wr_fin && a == VIC_OFF_EVT_STAT) begin
            s_nxt.evt_st = s_r.evt_st & ~pwdata[VIC_EVT_W-1:0];
        end
        s_nxt.evt_st = s_nxt.evt_st | evt;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.pend    <= VIC_RST_WORD;
            s_r.enab    <= VIC_RST_WORD;
            s_r.spu     <= VIC_RST_WORD;
            s_r.rdata   <= VIC_RST_WORD;
            s_r.slverr  <= 1'b0;
            s_r.ph      <= VIC_PH_IDLE;
            s_r.cur     <= VIC_RST_CUR;
            s_r.busy    <= 1'b0;
            s_r.fast_n  <= 1'b1;
            s_r.norm_n  <= 1'b1;
            s_r.evt_st  <= '0;
            s_r.evt_msk <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign pready               = s_r.ph == VIC_PH_DONE;
    assign prdata               = s_r.rdata;
    assign pslverr              = s_r.slverr & (s_r.ph == VIC_PH_DONE);
    assign fast_request_out_n   = s_r.fast_n;
    assign normal_request_out_n = s_r.norm_n;
    assign evt_irq              = |(s_r.evt_st & s_r.evt_msk);

endmodule

// ### vic_status_cmd_props.sv
// Checker: bus timing and readout relations of the status slice
module vic_status_cmd_props
    import vic_pkg::*;
(
    // Clock, reset and bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Sources, vector store, core lines
    input wire logic [31:0] src_req,
    input wire logic [4:0]  vec_sel,
    input wire logic [31:0] vec_data,
    input wire logic        fast_request_out_n,
    input wire logic        normal_request_out_n,
    input wire logic        evt_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] spu_q;
    wire done = psel && penable && pready;
    wire rd_n = done && !pwrite && paddr == VIC_OFF_NORM_VEC;
    wire rd_f = done && !pwrite && paddr == VIC_OFF_FAST_VEC;
    wire rd_c = done && !pwrite && paddr == VIC_OFF_CORE_REQ;

    // Shadow of the spurious vector; bench writes full words only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            spu_q <= VIC_RST_WORD;
        else if (done && pwrite && paddr == VIC_OFF_SPU_VEC)
            spu_q <= pwdata;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wait;
        !pready ##1 pready;
    endsequence
    sequence s_quiet;
        normal_request_out_n [*2];
    endsequence

    AST_READY_WAIT: assert property (psel && !penable |=> s_wait)
        else $error("ready not after exactly one wait state");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_ERR_READY: assert property (pslverr |-> pready && psel && penable)
        else $error("error flag outside a completing access");
    AST_NORM_VEC: assert property (rd_n && !normal_request_out_n
        |-> prdata == $past(vec_data)) else $error("normal vector wrong");
    AST_FAST_VEC: assert property (rd_f && !fast_request_out_n
        |-> prdata == $past(vec_data)) else $error("fast vector wrong");
    AST_SPU_NORM: assert property (rd_n && normal_request_out_n
        |-> prdata == spu_q) else $error("normal spurious vector wrong");
    AST_SPU_FAST: assert property (rd_f && fast_request_out_n
        |-> prdata == spu_q) else $error("fast spurious vector wrong");
    AST_CORE_FAST: assert property (rd_c && $stable(fast_request_out_n)
        |-> prdata[VIC_LINE_FAST_BIT] == !fast_request_out_n)
        else $error("core status fast bit wrong");
    AST_CORE_NORM: assert property (rd_c && $stable(normal_request_out_n)
        |-> prdata[VIC_LINE_NORM_BIT] == !normal_request_out_n)
        else $error("core status normal bit wrong");
    AST_NORM_SERVICE: assert property (rd_n && !normal_request_out_n
        |-> ##2 s_quiet) else $error("normal line kept during service");
endmodule

bind vic_status_cmd vic_status_cmd_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .src_req(src_req), .vec_sel(vec_sel), .vec_data(vec_data),
    .fast_request_out_n(fast_request_out_n),
    .normal_request_out_n(normal_request_out_n), .evt_irq(evt_irq)
);

// ### vic_status_cmd_test.sv
// Testbench: register, service and event scenarios for the status slice
module vic_status_cmd_test;
    timeunit 1ns;
    timeprecision 1ps;
    import vic_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        fast_request_out_n, normal_request_out_n, evt_irq;
    logic        fast_seen, norm_seen, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, src_req, vec_data, rd;
    logic [3:0]  pstrb;
    logic [4:0]  vec_sel;
    int          n_fail, n_tests;
    localparam logic [31:0] SPV = 32'h1234_5670;

    // --------
    // Vector store stand-in and instances
    // --------
    assign vec_data = 32'h5a00_0000 | {25'h0, vec_sel, 2'b00};
    always #5 pclk = ~pclk;
    vic_status_cmd u_vic_status_cmd (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .src_req(src_req), .vec_sel(vec_sel),
        .vec_data(vec_data), .fast_request_out_n(fast_request_out_n),
        .normal_request_out_n(normal_request_out_n), .evt_irq(evt_irq));
    vic_core_model u_vic_core_model (.pclk(pclk), .presetn(presetn),
        .fast_request_out_n(fast_request_out_n),
        .normal_request_out_n(normal_request_out_n),
        .fast_seen(fast_seen), .norm_seen(norm_seen));

    function automatic logic [31:0] vexp(input logic [4:0] n);
        return 32'h5a00_0000 | {25'h0, n, 2'b00};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // One idle cycle after each transfer keeps every drive unique per step
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) chk(32'h1, 32'h0);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // --------
    // Scenarios
    // --------
    task automatic t_reset;
        rdc(VIC_OFF_CUR_SRC, 32'h0);
        rdc(VIC_OFF_PENDING, 32'h0);
        rdc(VIC_OFF_ENABLED, 32'h0);
        rdc(VIC_OFF_CORE_REQ, 32'h0);
        rdc(VIC_OFF_SPU_VEC, 32'h0);
        rdc(12'h118, 32'h0);
        chk({31'h0, er}, 32'h1);
    endtask
    task automatic t_mask;
        wr(VIC_OFF_EN_CMD, 32'h0000_00f0);
        rdc(VIC_OFF_ENABLED, 32'h0000_00f0);
        wr(VIC_OFF_EN_CMD, 32'h8000_000c);
        rdc(VIC_OFF_ENABLED, 32'h8000_00fc);
        wr(VIC_OFF_DIS_CMD, 32'h8000_00f4);
        rdc(VIC_OFF_ENABLED, 32'h0000_0008);
        wr(VIC_OFF_ENABLED, 32'hffff_ffff);
        rdc(VIC_OFF_ENABLED, 32'h0000_0008);
    endtask
    task automatic t_pend;
        wr(VIC_OFF_SET_CMD, 32'h8000_0006);
        rdc(VIC_OFF_PENDING, 32'h8000_0006);
        wr(VIC_OFF_CLR_CMD, 32'h8000_0002);
        rdc(VIC_OFF_PENDING, 32'h0000_0004);
        rdc(VIC_OFF_CORE_REQ, 32'h0);
        wr(VIC_OFF_CLR_CMD, 32'h0000_0004);
    endtask
    task automatic t_service;
        wr(VIC_OFF_SPU_VEC, SPV);
        rdc(VIC_OFF_SPU_VEC, SPV);
        wr(VIC_OFF_SET_CMD, 32'h0000_0028);
        wr(VIC_OFF_EN_CMD, 32'h0000_0020);
        rdc(VIC_OFF_CORE_REQ, 32'h2);
        chk({31'h0, norm_seen}, 32'h1);
        rdc(VIC_OFF_NORM_VEC, vexp(5'd3));
        rdc(VIC_OFF_CUR_SRC, 32'h3);
        rdc(VIC_OFF_PENDING, 32'h20);
        rdc(VIC_OFF_CORE_REQ, 32'h0);
        chk({31'h0, norm_seen}, 32'h0);
        wr(VIC_OFF_EOS_CMD, 32'hdead_beef);
        rdc(VIC_OFF_NORM_VEC, vexp(5'd5));
        wr(VIC_OFF_EOS_CMD, 32'h0);
        rdc(VIC_OFF_NORM_VEC, SPV);
    endtask
    task automatic t_fast;
        wr(VIC_OFF_EN_CMD, 32'h1);
        src_req <= 32'h1;
        @(posedge pclk);
        src_req <= 32'h0;
        repeat (4) @(posedge pclk);
        chk({31'h0, fast_seen}, 32'h1);
        rdc(VIC_OFF_CORE_REQ, 32'h1);
        rdc(VIC_OFF_FAST_VEC, vexp(5'd0));
        rdc(VIC_OFF_FAST_VEC, SPV);
        rdc(VIC_OFF_CORE_REQ, 32'h0);
        chk({31'h0, fast_seen}, 32'h0);
    endtask
    task automatic t_evt;
        rdc(VIC_OFF_EVT_STAT, 32'h3);
        chk({31'h0, evt_irq}, 32'h0);
        wr(VIC_OFF_EVT_MASK, 32'h7);
        chk({31'h0, evt_irq}, 32'h1);
        wr(VIC_OFF_EVT_STAT, 32'h3);
        chk({31'h0, evt_irq}, 32'h0);
        wr(VIC_OFF_EOS_CMD, 32'h5);
        rdc(VIC_OFF_EVT_STAT, 32'h4);
        chk({31'h0, evt_irq}, 32'h1);
    endtask

    task automatic report_and_stop;
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        {pclk, presetn, psel, penable, pwrite} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        src_req = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_mask;
        t_pend;
        t_service;
        t_fast;
        t_evt;
        report_and_stop;
    end
    // Run needs about 190 cycles; allow about thirteen times that
    initial begin
        #25000;
        n_fail++;
        report_and_stop;
    end
endmodule
